// ### src/mlt_defines.svh
// Constants for the login check and the text message poll block
// Assumes inclusion by bare name from the package and the login text module
`ifndef MLT_DEFINES_SVH
`define MLT_DEFINES_SVH

`define MLT_MAX_FAILS      2'h3
`define MLT_PWD_DEPTH      16
`define MLT_BUF_DEPTH      240
`define MLT_CHUNK_LEN      60
`define MLT_STAMP_LEN      18
`define MLT_ACK_LEN        8'h06
`define MLT_ACK_FUNC       8'h10
`define MLT_ACK_ADDR       16'hcc30
`define MLT_ACK_COUNT      16'h0005
`define MLT_EXC_LEN        8'h04
`define MLT_EXC_FUNC       8'h90
`define MLT_EXC_CODE       8'h02
`define MLT_CHAR_SPACE     8'h20
`define MLT_CHAR_NULL      8'h00

`endif

// ### src/mlt_pkg.sv
// Types shared by the login check and text poll modules
// Assumes the defines header is on the include path
package mlt_pkg;
  `include "mlt_defines.svh"

  typedef enum logic [1:0] {RESP_NONE, RESP_ACK, RESP_NAK, RESP_EXC} mlt_resp_t;
  typedef enum logic [1:0] {LG_IDLE, LG_CALC, LG_CHECK} mlt_login_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_FILL, TX_SHOW} mlt_text_st_t;
endpackage

// ### src/mlt_cred_if.sv
// Byte stream from the login logic into the credential calculator
// Assumes one clock shared by both ends
`timescale 1ns/10ps
interface mlt_cred_if;
  logic        start;
  logic        byteValid;
  logic [7:0]  byteData;
  logic        byteLast;
  logic [7:0]  firstIpKey;
  logic [7:0]  secondIpKey;
  logic        done;
  logic [15:0] result;

  modport feed (output start, byteValid, byteData, byteLast, firstIpKey, secondIpKey, input done, result);
  modport calc (input start, byteValid, byteData, byteLast, firstIpKey, secondIpKey, output done, result);
endinterface

// ### src/mlt_cred_calc.sv
// Credential calculator: keys, chains and sums a password byte stream
// Assumes bytes arrive in order after start, one per cycle at most
`timescale 1ns/10ps
module mlt_cred_calc (
  input wire logic clk,
  input wire logic rst,
  mlt_cred_if.calc cred
);
  import mlt_pkg::*;

  logic        odd_r,  odd_nxt;
  logic        have_r, have_nxt;
  logic [7:0]  prev_r, prev_nxt;
  logic [15:0] sum_r,  sum_nxt;
  logic        done_r, done_nxt;
  logic [15:0] res_r,  res_nxt;

  always_comb begin
    logic [7:0] keyed;
    keyed    = 8'h00;
    odd_nxt  = odd_r;
    have_nxt = have_r;
    prev_nxt = prev_r;
    sum_nxt  = sum_r;
    done_nxt = 1'b0;
    res_nxt  = res_r;
    if (cred.start) begin
      odd_nxt  = 1'b0;
      have_nxt = 1'b0;
      sum_nxt  = 16'h0000;
    end else if (cred.byteValid) begin
      keyed    = cred.byteData ^ (odd_r ? cred.secondIpKey : cred.firstIpKey);
      odd_nxt  = ~odd_r;
      if (have_r)
        sum_nxt = sum_r + {8'h00, prev_r ^ keyed};
      prev_nxt = keyed;
      have_nxt = 1'b1;
      if (cred.byteLast) begin
        // Final byte stands unchained
        sum_nxt  = sum_nxt + {8'h00, keyed};
        done_nxt = 1'b1;
        res_nxt  = sum_nxt;
        have_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      odd_r  <= 1'b0;
      have_r <= 1'b0;
      prev_r <= 8'h00;
      sum_r  <= 16'h0000;
      done_r <= 1'b0;
      res_r  <= 16'h0000;
    end else begin
      odd_r  <= odd_nxt;
      have_r <= have_nxt;
      prev_r <= prev_nxt;
      sum_r  <= sum_nxt;
      done_r <= done_nxt;
      res_r  <= res_nxt;
    end
  end

  assign cred.done   = done_r;
  assign cred.result = res_r;

  chk_single_byte_sum: assert property (@(posedge clk) disable iff (rst)
    (cred.byteValid && cred.byteLast && !have_r && !cred.start && !odd_r)
      |=> (done_r && res_r == {8'h00, $past(cred.byteData) ^ $past(cred.firstIpKey)}))
    else $error("single byte credential wrong");
endmodule

// ### src/mlt_login_text.sv
// Login check and text message poll for the Modbus TCP slave link
// Assumes the transport layer decodes frames into the pulses below
`timescale 1ns/10ps
`include "mlt_defines.svh"
module mlt_login_text (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  secEnable,
  input  wire logic                  connOpen,
  input  wire logic [31:0]           ipAddr,
  input  wire logic                  remotePermit,
  input  wire logic                  pwdWe,
  input  wire logic [3:0]            pwdAddr,
  input  wire logic [7:0]            pwdData,
  input  wire logic [4:0]            pwdLen,
  input  wire logic                  loginReq,
  input  wire logic [15:0]           loginCred,
  input  wire logic                  reqValid,
  output logic                       reqPass,
  output logic                       loggedIn,
  output logic                       dropConn,
  output mlt_pkg::mlt_resp_t         respKind,
  output logic [7:0]                 respLen,
  output logic [7:0]                 respFunc,
  output logic [15:0]                respAddr,
  output logic [15:0]                respCount,
  output logic [7:0]                 respExc,
  input  wire logic                  msgValid,
  input  wire logic [7:0]            msgChar,
  input  wire logic                  msgLast,
  input  wire logic [143:0]          stampText,
  output logic                       msgReady,
  input  wire logic                  countClear,
  output logic [7:0]                 textCount,
  output logic [479:0]               chunkData
);
  import mlt_pkg::*;

  function automatic logic [7:0] ipByte(input logic [31:0] ip, input int n);
    ipByte = ip[8*(3-n) +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Login check
  logic [7:0]    pwdMem [`MLT_PWD_DEPTH];
  mlt_login_st_t lst_r, lst_nxt;
  logic [3:0]    pIdx_r, pIdx_nxt;
  logic [15:0]   cred_r, cred_nxt;
  logic [15:0]   calc_r, calc_nxt;
  logic [1:0]    fails_r, fails_nxt;
  logic          logged_r, logged_nxt;
  logic          drop_r, drop_nxt;
  logic          pass_r, pass_nxt;
  mlt_resp_t     kind_r, kind_nxt;
  logic [7:0]    len_r, len_nxt;
  logic [7:0]    func_r, func_nxt;
  mlt_cred_if    credBus ();

  mlt_cred_calc u_calc (
    .clk  (clk),
    .rst  (rst),
    .cred (credBus.calc)
  );

  assign credBus.firstIpKey  = ipByte(ipAddr, 0) ^ ipByte(ipAddr, 3);
  assign credBus.secondIpKey = ipByte(ipAddr, 1) ^ ipByte(ipAddr, 2);
  assign credBus.start       = (lst_r == LG_IDLE) && loginReq && connOpen;
  // Quiet while the result lands, or the last byte is summed twice
  assign credBus.byteValid   = (lst_r == LG_CALC) && !credBus.done;
  assign credBus.byteData    = pwdMem[pIdx_r];
  assign credBus.byteLast    = ({1'b0, pIdx_r} == pwdLen - 5'h01);

  always_ff @(posedge clk) begin
    if (pwdWe)
      pwdMem[pwdAddr] <= pwdData;
  end

  always_comb begin
    lst_nxt    = lst_r;
    pIdx_nxt   = pIdx_r;
    cred_nxt   = cred_r;
    calc_nxt   = calc_r;
    fails_nxt  = fails_r;
    logged_nxt = logged_r;
    drop_nxt   = 1'b0;
    kind_nxt   = RESP_NONE;
    pass_nxt   = reqValid && connOpen && (!secEnable || logged_r);
    case (lst_r)
      LG_IDLE: begin
        if (loginReq && connOpen) begin
          cred_nxt = loginCred;
          pIdx_nxt = 4'h0;
          if (pwdLen == 5'h00) begin
            calc_nxt = 16'h0000;
            lst_nxt  = LG_CHECK;
          end else begin
            lst_nxt = LG_CALC;
          end
        end
      end
      LG_CALC: begin
        pIdx_nxt = pIdx_r + 4'h1;
        if (credBus.byteLast)
          pIdx_nxt = pIdx_r;
        if (credBus.done) begin
          calc_nxt = credBus.result;
          lst_nxt  = LG_CHECK;
        end
      end
      LG_CHECK: begin
        lst_nxt = LG_IDLE;
        if (cred_r == calc_r && remotePermit) begin
          kind_nxt   = RESP_ACK;
          logged_nxt = 1'b1;
          fails_nxt  = 2'h0;
        end else if (fails_r == `MLT_MAX_FAILS - 2'h1) begin
          kind_nxt   = RESP_EXC;
          drop_nxt   = 1'b1;
          fails_nxt  = 2'h0;
          logged_nxt = 1'b0;
        end else begin
          kind_nxt   = RESP_NAK;
          fails_nxt  = fails_r + 2'h1;
          logged_nxt = 1'b0;
        end
      end
      default: lst_nxt = LG_IDLE;
    endcase
    if (!connOpen) begin
      lst_nxt    = LG_IDLE;
      fails_nxt  = 2'h0;
      logged_nxt = 1'b0;
      kind_nxt   = RESP_NONE;
      drop_nxt   = 1'b0;
    end
    len_nxt  = (kind_nxt == RESP_EXC) ? `MLT_EXC_LEN  : `MLT_ACK_LEN;
    func_nxt = (kind_nxt == RESP_EXC) ? `MLT_EXC_FUNC : `MLT_ACK_FUNC;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lst_r    <= LG_IDLE;
      pIdx_r   <= 4'h0;
      cred_r   <= 16'h0000;
      calc_r   <= 16'h0000;
      fails_r  <= 2'h0;
      logged_r <= 1'b0;
      drop_r   <= 1'b0;
      pass_r   <= 1'b0;
      kind_r   <= RESP_NONE;
      len_r    <= `MLT_ACK_LEN;
      func_r   <= `MLT_ACK_FUNC;
    end else begin
      lst_r    <= lst_nxt;
      pIdx_r   <= pIdx_nxt;
      cred_r   <= cred_nxt;
      calc_r   <= calc_nxt;
      fails_r  <= fails_nxt;
      logged_r <= logged_nxt;
      drop_r   <= drop_nxt;
      pass_r   <= pass_nxt;
      kind_r   <= kind_nxt;
      len_r    <= len_nxt;
      func_r   <= func_nxt;
    end
  end

  assign reqPass   = pass_r;
  assign loggedIn  = logged_r;
  assign dropConn  = drop_r;
  assign respKind  = kind_r;
  assign respLen   = len_r;
  assign respFunc  = func_r;
  assign respAddr  = `MLT_ACK_ADDR;
  assign respCount = `MLT_ACK_COUNT;
  assign respExc   = `MLT_EXC_CODE;

  chk_third_fail_drop: assert property (@(posedge clk) disable iff (rst)
    (lst_r == LG_CHECK && connOpen && !(cred_r == calc_r && remotePermit) && fails_r == 2'h2)
      |=> (dropConn && respKind == RESP_EXC && respFunc == 8'h90 && respExc == 8'h02))
    else $error("third failed login did not drop");
  chk_gate_requests: assert property (@(posedge clk) disable iff (rst)
    (reqValid && secEnable && !loggedIn) |=> !reqPass)
    else $error("request passed without login");
  chk_accept_ack: assert property (@(posedge clk) disable iff (rst)
    (lst_r == LG_CHECK && connOpen && cred_r == calc_r && remotePermit)
      |=> (respKind == RESP_ACK && loggedIn && respLen == 8'h06 && respAddr == 16'hcc30))
    else $error("accepted login not acknowledged");
  chk_permit_needed: assert property (@(posedge clk) disable iff (rst)
    (lst_r == LG_CHECK && !remotePermit) |=> (respKind != RESP_ACK && !loggedIn))
    else $error("login accepted without permission");
  chk_close_clears: assert property (@(posedge clk) disable iff (rst)
    !connOpen |=> (fails_r == 2'h0 && !loggedIn))
    else $error("session state survived close");

  ////////////////////////////////////////////////////////////////////////////
  // Text message delivery
  logic [7:0]   msgBuf [`MLT_BUF_DEPTH];
  logic [143:0] stamp_r, stamp_nxt;
  logic [7:0]   wIdx_r, wIdx_nxt;
  logic [8:0]   total_r, total_nxt;
  logic         full_r, full_nxt;
  logic         rdy_r, rdy_nxt;
  mlt_text_st_t tst_r, tst_nxt;
  logic [8:0]   base_r, base_nxt;
  logic [5:0]   fIdx_r, fIdx_nxt;
  logic         ext_r, ext_nxt;
  logic [7:0]   cnt_r, cnt_nxt;
  logic [7:0]   shown_r, shown_nxt;
  logic [479:0] chunk_r, chunk_nxt;
  logic [8:0]   charPos;
  logic [7:0]   charVal;
  logic         bufWe;

  assign bufWe   = msgValid && rdy_r;
  assign charPos = base_r + {3'h0, fIdx_r};

  always_ff @(posedge clk) begin
    if (bufWe && wIdx_r < 8'(`MLT_BUF_DEPTH))
      msgBuf[wIdx_r] <= msgChar;
  end

  always_comb begin
    charVal = `MLT_CHAR_NULL;
    if (ext_r)
      charVal = (fIdx_r == 6'h00) ? `MLT_CHAR_SPACE : `MLT_CHAR_NULL;
    else if (charPos < 9'(`MLT_STAMP_LEN))
      charVal = stamp_r[8*(`MLT_STAMP_LEN - 1 - charPos) +: 8];
    else if (charPos < total_r)
      charVal = msgBuf[8'(charPos - 9'(`MLT_STAMP_LEN))];
  end

  always_comb begin
    stamp_nxt = stamp_r;
    wIdx_nxt  = wIdx_r;
    total_nxt = total_r;
    full_nxt  = full_r;
    rdy_nxt   = rdy_r;
    tst_nxt   = tst_r;
    base_nxt  = base_r;
    fIdx_nxt  = fIdx_r;
    ext_nxt   = ext_r;
    cnt_nxt   = cnt_r;
    chunk_nxt = chunk_r;
    if (bufWe) begin
      if (wIdx_r == 8'h00)
        stamp_nxt = stampText;
      if (wIdx_r < 8'(`MLT_BUF_DEPTH))
        wIdx_nxt = wIdx_r + 8'h01;
      if (msgLast) begin
        full_nxt  = 1'b1;
        rdy_nxt   = 1'b0;
        total_nxt = 9'(`MLT_STAMP_LEN) + {1'b0, wIdx_nxt};
      end
    end
    case (tst_r)
      TX_IDLE: begin
        if (full_r && cnt_r == 8'h00) begin
          tst_nxt  = TX_FILL;
          fIdx_nxt = 6'h00;
        end
      end
      TX_FILL: begin
        chunk_nxt[8*(`MLT_CHUNK_LEN - 1 - fIdx_r) +: 8] = charVal;
        if (charVal != `MLT_CHAR_NULL)
          cnt_nxt = cnt_r + 8'h01;
        fIdx_nxt = fIdx_r + 6'h01;
        if (fIdx_r == 6'(`MLT_CHUNK_LEN - 1))
          tst_nxt = TX_SHOW;
      end
      TX_SHOW: begin
        if (countClear) begin
          cnt_nxt = 8'h00;
          tst_nxt = TX_IDLE;
          if (!ext_r && base_r + 9'(`MLT_CHUNK_LEN) <= total_r) begin
            base_nxt = base_r + 9'(`MLT_CHUNK_LEN);
            ext_nxt  = (base_r + 9'(`MLT_CHUNK_LEN) == total_r);
            tst_nxt  = TX_FILL;
            fIdx_nxt = 6'h00;
          end else begin
            base_nxt = 9'h000;
            ext_nxt  = 1'b0;
            full_nxt = 1'b0;
            wIdx_nxt = 8'h00;
            rdy_nxt  = 1'b1;
          end
        end
      end
      default: tst_nxt = TX_IDLE;
    endcase
    shown_nxt = (tst_nxt == TX_SHOW) ? cnt_nxt : 8'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stamp_r <= 144'h0;
      wIdx_r  <= 8'h00;
      total_r <= 9'h000;
      full_r  <= 1'b0;
      rdy_r   <= 1'b1;
      tst_r   <= TX_IDLE;
      base_r  <= 9'h000;
      fIdx_r  <= 6'h00;
      ext_r   <= 1'b0;
      cnt_r   <= 8'h00;
      chunk_r <= 480'h0;
      shown_r <= 8'h00;
    end else begin
      stamp_r <= stamp_nxt;
      wIdx_r  <= wIdx_nxt;
      total_r <= total_nxt;
      full_r  <= full_nxt;
      rdy_r   <= rdy_nxt;
      tst_r   <= tst_nxt;
      base_r  <= base_nxt;
      fIdx_r  <= fIdx_nxt;
      ext_r   <= ext_nxt;
      cnt_r   <= cnt_nxt;
      chunk_r <= chunk_nxt;
      shown_r <= shown_nxt;
    end
  end

  // Count visible only when whole chunk ready
  assign textCount = shown_r;
  assign chunkData = chunk_r;
  assign msgReady  = rdy_r;

  chk_hold_chunk: assert property (@(posedge clk) disable iff (rst)
    (tst_r == TX_SHOW && !countClear) |=> (tst_r == TX_SHOW && $stable(chunkData)))
    else $error("chunk changed before acknowledge");
  chk_extension_form: assert property (@(posedge clk) disable iff (rst)
    (tst_r == TX_SHOW && ext_r) |-> (textCount == 8'h01 && chunkData[479:472] == 8'h20
      && chunkData[471:0] == 472'h0))
    else $error("extension chunk malformed");
  chk_fill_length: assert property (@(posedge clk) disable iff (rst)
    (tst_r == TX_IDLE && full_r && cnt_r == 8'h00) |=> (tst_r == TX_FILL) ##60 (tst_r == TX_SHOW))
    else $error("chunk fill took wrong time");
endmodule

// ### bench/mlt_host_model.sv
// Host model: polls the character count, reads the message area, then clears it
// Assumes the poll block updates on the rising edge; this model acts on the falling one
`timescale 1ns/10ps
module mlt_host_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   holdCycles,
  input  wire logic         clrLog,
  input  wire logic [7:0]   textCount,
  input  wire logic [479:0] chunkData,
  output logic              countClear
);
  logic [479:0] gotFirst [0:7];
  logic [479:0] gotLast  [0:7];
  logic [7:0]   gotCnt   [0:7];
  int           gotN;
  logic [7:0]   waitCnt;

  always @(negedge clk or posedge rst) begin
    if (rst) begin
      countClear <= 1'b0;
      gotN <= 0;
      waitCnt <= 8'h00;
    end else begin
      countClear <= 1'b0;
      if (clrLog) begin
        gotN <= 0;
      end else if (!countClear && textCount != 8'h00 && gotN < 8) begin
        // First look kept apart so a slow host can see whether the chunk held still
        if (waitCnt == 8'h00) begin
          gotFirst[gotN] <= chunkData;
        end
        if (waitCnt == holdCycles) begin
          gotLast[gotN] <= chunkData;
          gotCnt[gotN] <= textCount;
          gotN <= gotN + 1;
          countClear <= 1'b1;
          waitCnt <= 8'h00;
        end else begin
          waitCnt <= waitCnt + 8'h01;
        end
      end
    end
  end
endmodule

// ### bench/test_mlt_login_text.sv
// Bench for the login check and text poll block, with a polling host model
// Assumes the design package and the host model are compiled first
`timescale 1ns/10ps
module test_mlt_login_text;
  import mlt_pkg::*;
  logic           clk, rst, secEnable, connOpen, remotePermit, pwdWe, loginReq, reqValid;
  logic [31:0]    ipAddr;
  logic [3:0]     pwdAddr;
  logic [7:0]     pwdData, respLen, respFunc, respExc, msgChar, textCount, hostHold;
  logic [4:0]     pwdLen;
  logic [15:0]    loginCred, respAddr, respCount;
  logic           reqPass, loggedIn, dropConn, msgValid, msgLast, msgReady, countClear, hostClr;
  mlt_resp_t      respKind;
  logic [143:0]   stampText;
  logic [479:0]   chunkData;
  logic [143:0]   stamp = "01/02/03 10:20:30 ";
  int             errTotal = 0;
  int             testsRun = 0;

  mlt_login_text u_mlt_login_text (
    .clk(clk), .rst(rst), .secEnable(secEnable), .connOpen(connOpen), .ipAddr(ipAddr),
    .remotePermit(remotePermit), .pwdWe(pwdWe), .pwdAddr(pwdAddr), .pwdData(pwdData),
    .pwdLen(pwdLen), .loginReq(loginReq), .loginCred(loginCred), .reqValid(reqValid),
    .reqPass(reqPass), .loggedIn(loggedIn), .dropConn(dropConn), .respKind(respKind),
    .respLen(respLen), .respFunc(respFunc), .respAddr(respAddr), .respCount(respCount),
    .respExc(respExc), .msgValid(msgValid), .msgChar(msgChar), .msgLast(msgLast),
    .stampText(stampText), .msgReady(msgReady), .countClear(countClear),
    .textCount(textCount), .chunkData(chunkData));

  mlt_host_model u_mlt_host_model (
    .clk(clk), .rst(rst), .holdCycles(hostHold), .clrLog(hostClr), .textCount(textCount),
    .chunkData(chunkData), .countClear(countClear));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [479:0] seen, input logic [479:0] exp, input string what);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic finalReport();
    $display("Checks %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] calc_cred(input string s);
    logic [7:0]  e [0:15];
    logic [15:0] sum;
    sum = 16'h0000;
    for (int i = 0; i < s.len(); i++) begin
      e[i] = s[i] ^ ((i % 2) ? (ipAddr[23:16] ^ ipAddr[15:8]) : (ipAddr[31:24] ^ ipAddr[7:0]));
    end
    for (int i = 0; i < s.len() - 1; i++) begin
      e[i] = e[i] ^ e[i + 1];
    end
    for (int i = 0; i < s.len(); i++) begin
      sum = sum + {8'h00, e[i]};
    end
    return sum;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic set_pwd(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      pwdWe = 1'b1;
      pwdAddr = 4'(i);
      pwdData = s[i];
    end
    @(negedge clk);
    pwdWe = 1'b0;
    pwdLen = 5'(s.len());
  endtask

  task automatic reopen();
    @(negedge clk);
    connOpen = 1'b0;
    @(negedge clk);
    connOpen = 1'b1;
  endtask

  task automatic do_request(output logic pass);
    @(negedge clk);
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    pass = reqPass;
    @(negedge clk);
    reqValid = 1'b0;
  endtask

  task automatic do_login(input logic [15:0] cred, output mlt_resp_t kind, output logic drop);
    int n;
    @(negedge clk);
    loginReq = 1'b1;
    loginCred = cred;
    @(negedge clk);
    loginReq = 1'b0;
    n = 0;
    kind = RESP_NONE;
    while (kind === RESP_NONE && n < 40) begin
      @(posedge clk);
      #1;
      n++;
      kind = respKind;
      drop = dropConn;
    end
    check(n, (pwdLen == 5'h00) ? 1 : pwdLen + 2, "login latency");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_security();
    logic p;
    do_request(p);
    check(p, 1'b1, "request refused, security off");
    @(negedge clk);
    secEnable = 1'b1;
    do_request(p);
    check(p, 1'b0, "request passed without login");
  endtask

  task automatic t_fail();
    mlt_resp_t  k;
    logic       d;
    logic [15:0] bad;
    set_pwd("pw1");
    bad = calc_cred("pw1") ^ 16'h0101;
    for (int i = 0; i < 3; i++) begin
      do_login(bad, k, d);
      check(k, (i < 2) ? RESP_NAK : RESP_EXC, "failed login answer");
      check(d, i == 2, "drop after third failure");
    end
    check({respLen, respFunc, respExc}, 24'h049002, "exception frame");
    reopen();
    do_login(bad, k, d);
    do_login(bad, k, d);
    reopen();
    do_login(bad, k, d);
    check({k, d}, {RESP_NAK, 1'b0}, "fail count kept over close");
    reopen();
  endtask

  task automatic t_permit();
    mlt_resp_t k;
    logic      d;
    logic      p;
    @(negedge clk);
    remotePermit = 1'b0;
    do_login(calc_cred("pw1"), k, d);
    check({k, loggedIn}, {RESP_NAK, 1'b0}, "login without permission");
    @(negedge clk);
    remotePermit = 1'b1;
    do_login(calc_cred("pw1"), k, d);
    check(k, RESP_ACK, "good credential refused");
    check({respLen, respFunc, respAddr, respCount}, 48'h0610cc300005, "ack frame");
    do_request(p);
    check({loggedIn, p}, 2'h3, "request after login");
  endtask

  task automatic t_empty();
    mlt_resp_t k;
    logic      d;
    reopen();
    check(loggedIn, 1'b0, "login kept over close");
    @(negedge clk);
    pwdLen = 5'h00;
    do_login(16'h0000, k, d);
    check(k, RESP_ACK, "empty password refused");
    set_pwd("k");
    do_login(calc_cred("k"), k, d);
    check(k, RESP_ACK, "single character password refused");
  endtask

  task automatic t_msg(input int bodyLen, input logic [7:0] hold);
    logic [7:0]   all [$];
    logic [479:0] ex;
    int           nCh;
    int           cnt;
    int           idx;
    for (int i = 0; i < 18; i++) all.push_back(stamp[143 - 8 * i -: 8]);
    for (int i = 0; i < bodyLen; i++) all.push_back(8'h41 + i % 26);
    nCh = (all.size() + 59) / 60 + (all.size() % 60 == 0);
    @(negedge clk);
    hostHold = hold;
    hostClr = 1'b1;
    repeat (2) @(negedge clk);
    hostClr = 1'b0;
    check(textCount, 8'h00, "count with nothing queued");
    for (int i = 0; i < bodyLen; i++) begin
      msgValid = 1'b1;
      msgChar = 8'h41 + i % 26;
      msgLast = (i == bodyLen - 1);
      @(negedge clk);
    end
    msgValid = 1'b0;
    msgLast = 1'b0;
    for (int n = 0; n < 3000 && u_mlt_host_model.gotN < nCh; n++) @(negedge clk);
    check(u_mlt_host_model.gotN, nCh, "chunk total");
    for (int k = 0; k < nCh; k++) begin
      cnt = 0;
      for (int p = 0; p < 60; p++) begin
        idx = k * 60 + p;
        ex[479 - 8 * p -: 8] = (idx < all.size()) ? all[idx] :
                               (idx == all.size() && all.size() % 60 == 0) ? 8'h20 : 8'h00;
        cnt += (ex[479 - 8 * p -: 8] != 8'h00);
      end
      check(u_mlt_host_model.gotLast[k], ex, "chunk content");
      check(u_mlt_host_model.gotFirst[k], ex, "chunk moved before clear");
      check(u_mlt_host_model.gotCnt[k], cnt, "character count");
    end
    for (int n = 0; n < 100 && msgReady !== 1'b1; n++) @(negedge clk);
    check(msgReady, 1'b1, "queue not freed");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Slack of over fifty times the expected run
  initial begin
    #400000;
    errTotal++;
    finalReport();
  end

  initial begin
    rst = 1'b1;
    {secEnable, pwdWe, loginReq, reqValid, msgValid, msgLast, hostClr} = 7'h00;
    {connOpen, remotePermit} = 2'h3;
    ipAddr = 32'hc0a8010a;
    pwdAddr = 4'h0;
    pwdData = 8'h00;
    pwdLen = 5'h00;
    loginCred = 16'h0000;
    msgChar = 8'h00;
    stampText = stamp;
    hostHold = 8'h00;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_security();
    t_fail();
    t_permit();
    t_empty();
    t_msg(8, 8'h14);
    t_msg(42, 8'h00);
    t_msg(70, 8'h03);
    finalReport();
  end
endmodule
